//--- verilog/pmra_regs.svh
// register map, field positions, reset values and constants of the power monitor
`ifndef PMRA_REGS_SVH
`define PMRA_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PMRA_A_CFG      8'h00
`define PMRA_A_ADCCFG   8'h04
`define PMRA_A_CAL      8'h08
`define PMRA_A_SOL      8'h0C
`define PMRA_A_BOL      8'h10
`define PMRA_A_PWL      8'h14
`define PMRA_A_ALEN     8'h18
`define PMRA_A_SHUNT    8'h20
`define PMRA_A_BUS      8'h24
`define PMRA_A_TEMP     8'h28
`define PMRA_A_CUR      8'h2C
`define PMRA_A_PWR      8'h30
`define PMRA_A_FLAGS    8'h34
`define PMRA_A_IST      8'h38
`define PMRA_A_ICLR     8'h3C
`define PMRA_A_IEN      8'h40

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define PMRA_F_RANGE    0
`define PMRA_F_CNVRSEL  1
`define PMRA_F_AVG      2:0
`define PMRA_F_TCT      5:3
`define PMRA_F_SCT      8:6
`define PMRA_F_BCT      11:9
`define PMRA_F_MODE     13:12
`define PMRA_EV_SHUNT   0
`define PMRA_EV_BUS     1
`define PMRA_EV_PWR     2
`define PMRA_EV_CNVR    3

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define PMRA_CFG_RST    16'h0000
`define PMRA_ADCCFG_RST 16'h3B68
`define PMRA_CAL_RST    16'h0000
`define PMRA_SOL_RST    16'h7FFF
`define PMRA_BOL_RST    16'h7FFF
`define PMRA_PWL_RST    16'hFFFF
`define PMRA_FAST_MARGIN 17'h0_0800
`define PMRA_CUR_SHIFT  11
`define PMRA_PWR_SHIFT  6

`endif

//--- verilog/pmra_pkg.sv
// types shared by the power monitor result and alert logic
package pmra_pkg;

  typedef enum logic [1:0] {
    KIND_SHUNT,
    KIND_BUS,
    KIND_TEMP
  } pmra_kind_t;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_SHUNT,
    MODE_BUS,
    MODE_ALL
  } pmra_mode_t;

endpackage

//--- verilog/pmra_top.sv
// result formatting, limit comparison and alert logic of the power monitor
// Function
// - separate shunt/bus conversion times, independent averaging
// - reset: wide range, continuous shunt-bus-temp
// - zero calibration gives zero current and power
// - power step is current step times 0.2
// - shunt limit compared in shunt-voltage steps
// - bus limit uses bus-voltage result steps
// - power limit compares power result bits 23:8
// - limits, configuration, calibration default at power-up
// - signed results, bus and power results never negative
// - alert source: limit event or conversion ready
// - marginal fault alert within 1.5 conversion periods
// - large shunt or bus fault alerts within quarter conversion
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pmra_regs.svh"

module pmra_top
  import pmra_pkg::*;
(
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // converter
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic        fast_valid,
  input  wire logic [15:0] fast_data,
  output pmra_kind_t       conv_kind,
  output logic [2:0]       conv_time,
  output logic             conv_run,
  output logic             adc_range,
  // alert and interrupt
  output logic             alert,
  output logic             irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]        cfg_ff, adccfg_ff, cal_ff, sol_ff, bol_ff, pwl_ff;
  logic [2:0]         alen_ff;
  logic [3:0]         ist_ff, ien_ff;
  logic [2:0]         lim_ff;
  logic               cnvr_ff;
  logic [15:0]        shunt_ff, bus_ff, temp_ff, cur_ff;
  logic [23:0]        pwr_ff;
  logic signed [25:0] acc_ff [3];
  logic [9:0]         cnt_ff;
  pmra_kind_t         kind_ff;
  logic               done_ff;
  logic               aw_hold_ff, w_hold_ff;
  logic [7:0]         awaddr_ff, araddr_c;
  logic [31:0]        wdata_ff;
  logic [3:0]         wstrb_ff;
  logic               rd_flags;

  pmra_mode_t         mode;
  pmra_kind_t         last_kind, nxt_kind;
  logic [3:0]         shift;
  logic               fin, wr_go, wr_hit, adc_wr;
  logic signed [25:0] smp_ext, sum_cur;
  logic [31:0]        rd_c;
  logic               rd_hit;

  assign mode    = pmra_mode_t'(adccfg_ff[`PMRA_F_MODE]);
  assign smp_ext = {{10{sample_data[15]}}, sample_data};
  assign sum_cur = acc_ff[kind_ff] + smp_ext;
  assign wr_go   = ce && aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  assign adc_wr  = wr_go && (awaddr_ff == `PMRA_A_ADCCFG);

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old);
    merge[7:0]  = wstrb_ff[0] ? wdata_ff[7:0] : old[7:0];
    merge[15:8] = wstrb_ff[1] ? wdata_ff[15:8] : old[15:8];
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff    <= 1'b0;
      w_hold_ff     <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else if (ce) begin
      // ready drops the cycle an item is taken, so one write is held at most
      s_axi_awready <= !aw_hold_ff && !(s_axi_awvalid && s_axi_awready) && !wr_go && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_ff && !(s_axi_wvalid && s_axi_wready) && !wr_go && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (awaddr_ff)
      `PMRA_A_CFG, `PMRA_A_ADCCFG, `PMRA_A_CAL, `PMRA_A_SOL, `PMRA_A_BOL,
      `PMRA_A_PWL, `PMRA_A_ALEN, `PMRA_A_ICLR, `PMRA_A_IEN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // configuration, calibration and limits
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff    <= `PMRA_CFG_RST;
      adccfg_ff <= `PMRA_ADCCFG_RST;
      cal_ff    <= `PMRA_CAL_RST;
      sol_ff    <= `PMRA_SOL_RST;
      bol_ff    <= `PMRA_BOL_RST;
      pwl_ff    <= `PMRA_PWL_RST;
      alen_ff   <= 3'b000;
      ien_ff    <= 4'h0;
    end else if (wr_go) begin
      case (awaddr_ff)
        `PMRA_A_CFG:    cfg_ff    <= merge(cfg_ff);
        `PMRA_A_ADCCFG: adccfg_ff <= merge(adccfg_ff);
        `PMRA_A_CAL:    cal_ff    <= merge(cal_ff) & 16'h7FFF;
        `PMRA_A_SOL:    sol_ff    <= merge(sol_ff);
        `PMRA_A_BOL:    bol_ff    <= merge(bol_ff) & 16'h7FFF;
        `PMRA_A_PWL:    pwl_ff    <= merge(pwl_ff);
        `PMRA_A_ALEN:   alen_ff   <= wstrb_ff[0] ? wdata_ff[2:0] : alen_ff;
        `PMRA_A_IEN:    ien_ff    <= wstrb_ff[0] ? wdata_ff[3:0] : ien_ff;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // conversion sequence and averaging
  // ----------------------------------------------------------------
  always_comb begin
    case (adccfg_ff[`PMRA_F_AVG])
      3'd0:    shift = 4'd0;
      3'd1:    shift = 4'd2;
      3'd2:    shift = 4'd4;
      3'd3:    shift = 4'd6;
      3'd4:    shift = 4'd7;
      3'd5:    shift = 4'd8;
      3'd6:    shift = 4'd9;
      default: shift = 4'd10;
    endcase
    case (mode)
      MODE_SHUNT: begin
        last_kind = KIND_SHUNT;
        nxt_kind  = KIND_SHUNT;
      end
      MODE_BUS: begin
        last_kind = KIND_BUS;
        nxt_kind  = KIND_BUS;
      end
      default: begin
        last_kind = KIND_TEMP;
        case (kind_ff)
          KIND_SHUNT: nxt_kind = KIND_BUS;
          KIND_BUS:   nxt_kind = KIND_TEMP;
          default:    nxt_kind = KIND_SHUNT;
        endcase
      end
    endcase
  end

  // results latch only when the averaging period closes
  assign fin = ce && conv_run && sample_valid && kind_ff == last_kind
               && cnt_ff == 10'((11'd1 << shift) - 11'd1) && !adc_wr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // continuous all-channel sequence starts on the shunt
      kind_ff   <= KIND_SHUNT;
      conv_time <= 3'd0;
      conv_run  <= 1'b0;
      adc_range <= 1'b0;
    end else if (ce) begin
      conv_run  <= mode != MODE_OFF;
      // wide shunt range unless software picks narrow
      adc_range <= cfg_ff[`PMRA_F_RANGE];
      if (adc_wr) begin
        kind_ff <= (mode == MODE_BUS) ? KIND_BUS : KIND_SHUNT;
      end else if (conv_run && sample_valid) begin
        kind_ff <= nxt_kind;
      end
      case (kind_ff)
        KIND_SHUNT: conv_time <= adccfg_ff[`PMRA_F_SCT];
        KIND_BUS:   conv_time <= adccfg_ff[`PMRA_F_BCT];
        default:    conv_time <= adccfg_ff[`PMRA_F_TCT];
      endcase
    end
  end
  assign conv_kind = kind_ff;

  // averaging count independent of conversion times
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= '{default: 26'sd0};
      cnt_ff <= 10'd0;
    end else if (ce) begin
      // a new setting restarts the average rather than mixing two
      if (adc_wr) begin
        acc_ff <= '{default: 26'sd0};
        cnt_ff <= 10'd0;
      end else if (fin) begin
        acc_ff <= '{default: 26'sd0};
        cnt_ff <= 10'd0;
      end else if (conv_run && sample_valid) begin
        acc_ff[kind_ff] <= sum_cur;
        if (kind_ff == last_kind) begin
          cnt_ff <= cnt_ff + 10'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // results
  // ----------------------------------------------------------------
  function automatic logic [15:0] avg_of(input logic signed [25:0] a, input logic [3:0] s);
    logic signed [25:0] q;
    q      = a >>> s;
    avg_of = q[15:0];
  endfunction

  logic signed [31:0] cur_prod;
  logic [15:0]        cur_c, cur_mag, bus_avg;
  logic [31:0]        pwr_prod;
  logic [23:0]        pwr_c;

  assign cur_prod = $signed(shunt_ff) * $signed({1'b0, cal_ff[14:0]});
  assign cur_c    = (cal_ff[14:0] == 15'h0000) ? 16'h0000 : cur_prod[`PMRA_CUR_SHIFT+15:`PMRA_CUR_SHIFT];
  assign cur_mag  = cur_c[15] ? 16'(~cur_c + 16'h0001) : cur_c;
  // current*bus/64 gives power steps of 0.2 current steps
  assign pwr_prod = cur_mag * bus_ff;
  assign pwr_c    = (pwr_prod[31:30] != 2'b00) ? 24'hFF_FFFF : pwr_prod[`PMRA_PWR_SHIFT+23:`PMRA_PWR_SHIFT];
  assign bus_avg  = avg_of(kind_ff == KIND_BUS ? sum_cur : acc_ff[KIND_BUS], shift);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shunt_ff <= 16'h0000;
      bus_ff   <= 16'h0000;
      temp_ff  <= 16'h0000;
      cur_ff   <= 16'h0000;
      pwr_ff   <= 24'h00_0000;
      done_ff  <= 1'b0;
    end else if (ce) begin
      done_ff <= fin;
      if (fin) begin
        if (mode != MODE_BUS) begin
          shunt_ff <= avg_of(kind_ff == KIND_SHUNT ? sum_cur : acc_ff[KIND_SHUNT], shift);
        end
        if (mode != MODE_SHUNT) begin
          bus_ff <= bus_avg[15] ? 16'h0000 : bus_avg;
        end
        if (mode == MODE_ALL) begin
          temp_ff <= avg_of(sum_cur, shift);
        end
      end
      if (done_ff) begin
        cur_ff <= cur_c;
        pwr_ff <= pwr_c;
      end
    end
  end

  // ----------------------------------------------------------------
  // limit comparison, status and alert
  // ----------------------------------------------------------------
  logic [2:0] cmp, fast_ev, lim_ev;
  logic [3:0] ev, iclr, nxt_ist;

  // averaged result above limit raises the event
  // shunt limit in raw shunt-voltage steps
  assign cmp[`PMRA_EV_SHUNT] = $signed(shunt_ff) > $signed(sol_ff);
  assign cmp[`PMRA_EV_BUS]   = bus_ff > bol_ff;
  // power limit against power bits 23:8
  assign cmp[`PMRA_EV_PWR]   = pwr_c[23:8] > pwl_ff;

  // large shunt or bus fault trips on a partial conversion; power has no fast trip
  assign fast_ev[`PMRA_EV_SHUNT] = conv_run && fast_valid && kind_ff == KIND_SHUNT
                                   && $signed({fast_data[15], fast_data})
                                      > $signed({sol_ff[15], sol_ff}) + $signed(`PMRA_FAST_MARGIN);
  assign fast_ev[`PMRA_EV_BUS]   = conv_run && fast_valid && kind_ff == KIND_BUS && !fast_data[15]
                                   && {1'b0, fast_data} > {1'b0, bol_ff} + `PMRA_FAST_MARGIN;
  assign fast_ev[`PMRA_EV_PWR]   = 1'b0;

  assign lim_ev  = (done_ff ? cmp : 3'b000) | fast_ev;
  assign ev      = ce ? {done_ff, lim_ev} : 4'h0;
  assign iclr    = (wr_go && awaddr_ff == `PMRA_A_ICLR && wstrb_ff[0]) ? wdata_ff[3:0] : 4'h0;
  // a new event wins over a clear in the same cycle
  assign nxt_ist = (ist_ff & ~iclr) | ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lim_ff  <= 3'b000;
      cnvr_ff <= 1'b0;
      ist_ff  <= 4'h0;
      irq     <= 1'b0;
      alert   <= 1'b0;
    end else if (ce) begin
      // marginal fault seen at the next completed conversion
      if (done_ff) begin
        lim_ff <= cmp | fast_ev;
      end else begin
        lim_ff <= lim_ff | fast_ev;
      end
      if (done_ff) begin
        cnvr_ff <= 1'b1;
      end else if (rd_flags) begin
        cnvr_ff <= 1'b0;
      end
      ist_ff <= nxt_ist;
      irq    <= |(nxt_ist & ien_ff);
      // alert follows conversion ready or enabled limits
      if (cfg_ff[`PMRA_F_CNVRSEL]) begin
        alert <= cnvr_ff || done_ff;
      end else begin
        alert <= |(lim_ev & alen_ff) || (!done_ff && |(lim_ff & alen_ff));
      end
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `PMRA_A_CFG:    rd_c = {16'h0000, cfg_ff};
      `PMRA_A_ADCCFG: rd_c = {16'h0000, adccfg_ff};
      `PMRA_A_CAL:    rd_c = {16'h0000, cal_ff};
      `PMRA_A_SOL:    rd_c = {16'h0000, sol_ff};
      `PMRA_A_BOL:    rd_c = {16'h0000, bol_ff};
      `PMRA_A_PWL:    rd_c = {16'h0000, pwl_ff};
      `PMRA_A_ALEN:   rd_c = {29'h0000_0000, alen_ff};
      `PMRA_A_SHUNT:  rd_c = {{16{shunt_ff[15]}}, shunt_ff};
      `PMRA_A_BUS:    rd_c = {16'h0000, bus_ff};
      `PMRA_A_TEMP:   rd_c = {{16{temp_ff[15]}}, temp_ff};
      `PMRA_A_CUR:    rd_c = {{16{cur_ff[15]}}, cur_ff};
      `PMRA_A_PWR:    rd_c = {8'h00, pwr_ff};
      `PMRA_A_FLAGS:  rd_c = {28'h000_0000, cnvr_ff, lim_ff};
      `PMRA_A_IST:    rd_c = {28'h000_0000, ist_ff};
      `PMRA_A_ICLR:   rd_c = 32'h0000_0000;
      `PMRA_A_IEN:    rd_c = {28'h000_0000, ien_ff};
      default: begin
        rd_c   = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign araddr_c = s_axi_araddr;
  // reading the live flags acknowledges conversion ready
  assign rd_flags = s_axi_arvalid && s_axi_arready && araddr_c == `PMRA_A_FLAGS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_c;
        s_axi_rresp   <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // pmra_top

//--- testbench/pmra_monitor.sv
// bus handshake, reset and channel order checks on the power monitor ports
`timescale 1ns/10ps

module pmra_monitor
  import pmra_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // converter and alert
  input wire logic        sample_valid,
  input wire pmra_kind_t  conv_kind,
  input wire logic        conv_run,
  input wire logic        alert,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");

  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");

  property p_wresp;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wresp: assert property (p_wresp) else $error("write response late");

  property p_rresp;
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read response late");

  property p_arblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_arblk: assert property (p_arblk) else $error("read taken during response");

  property p_awblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_awblk: assert property (p_awblk) else $error("write taken during response");

  property p_rstout;
    $rose(aresetn) |-> !alert && !irq && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rstout: assert property (p_rstout) else $error("outputs not cleared by reset");

  property p_order;
    ce && conv_run && sample_valid && conv_kind == KIND_TEMP |=> conv_kind == KIND_SHUNT;
  endproperty
  a_order: assert property (p_order) else $error("temperature not followed by shunt");
endmodule // pmra_monitor

//--- testbench/pmra_conv_model.sv
// converter model: one sample per gap for the channel the block asks for
`timescale 1ns/10ps

module pmra_conv_model
  import pmra_pkg::*;
#(
  parameter int GAP = 8
)
(
  // clock and control
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire pmra_kind_t  conv_kind,
  input  wire logic        conv_run,
  // values to report
  input  wire logic [15:0] sh,
  input  wire logic [15:0] bu,
  input  wire logic [15:0] te,
  // results
  output logic             sample_valid,
  output logic [15:0]      sample_data,
  output logic             fast_valid,
  output logic [15:0]      fast_data
);
  logic [7:0]  cnt_ff = 8'h00;
  logic [15:0] val;

  assign val = (conv_kind == KIND_SHUNT) ? sh : (conv_kind == KIND_BUS) ? bu : te;
  // count held at zero while conversion is halted, restarting from zero
  always @(posedge aclk) begin
    if (!aresetn || conv_run !== 1'b1 || cnt_ff == 8'(GAP - 1)) cnt_ff <= 8'h00;
    else cnt_ff <= cnt_ff + 8'h01;
  end
  assign sample_valid = conv_run === 1'b1 && cnt_ff == 8'(GAP - 1);
  assign fast_valid   = conv_run === 1'b1 && cnt_ff == 8'(GAP / 4);
  // data lines are junk outside their strobe
  assign sample_data  = sample_valid ? val : ~val;
  assign fast_data    = fast_valid ? val : ~val;
endmodule // pmra_conv_model

//--- testbench/tb_top.sv
// self-checking testbench of the power monitor result and alert block
`timescale 1ns/10ps
`include "pmra_regs.svh"

module tb_top
  import pmra_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sample_valid, fast_valid;
  logic        conv_run, adc_range, alert, irq;
  logic [1:0]  bresp, rresp, last_b, last_r;
  logic [15:0] sample_data, fast_data, sh = 16'h0000, bu = 16'h0000, te = 16'h0000;
  logic [2:0]  conv_time;
  pmra_kind_t  conv_kind;
  int          fails = 0, checks = 0;
  logic [7:0]  ra [7] = '{`PMRA_A_CFG, `PMRA_A_ADCCFG, `PMRA_A_CAL, `PMRA_A_SOL, `PMRA_A_BOL, `PMRA_A_PWL,
                          `PMRA_A_ALEN};
  logic [31:0] rv [7] = '{32'h0000_0000, 32'h0000_3B68, 32'h0000_0000, 32'h0000_7FFF, 32'h0000_7FFF,
                          32'h0000_FFFF, 32'h0000_0000};

  pmra_top uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sample_valid(sample_valid), .sample_data(sample_data),
    .fast_valid(fast_valid), .fast_data(fast_data), .conv_kind(conv_kind), .conv_time(conv_time),
    .conv_run(conv_run), .adc_range(adc_range), .alert(alert), .irq(irq));
  pmra_conv_model #(.GAP(8)) u_conv (.aclk(aclk), .aresetn(aresetn), .conv_kind(conv_kind),
    .conv_run(conv_run), .sh(sh), .bu(bu), .te(te), .sample_valid(sample_valid),
    .sample_data(sample_data), .fast_valid(fast_valid), .fast_data(fast_data));

  initial begin
    forever #20 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 64) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    n = 0; aw = 1'b1; w = 1'b1;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (aw && awready === 1'b1) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready === 1'b1) begin w = 1'b0; wvalid <= 1'b0; end
    end while ((aw || w) && n < 64);
    bready <= 1'b1;
    do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 64);
    last_b = bresp;
    bready <= 1'b0;
    guard(n);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1;
    do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 64);
    arvalid <= 1'b0; rready <= 1'b1;
    do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 64);
    d = rdata; last_r = rresp;
    rready <= 1'b0;
    guard(n);
  endtask
  // two period ends, so the second, full period reflects the current inputs
  task automatic settle();
    logic [31:0] d;
    int n;
    repeat (2) begin
      n = 0;
      wr(`PMRA_A_ICLR, 32'h0000_0008);
      do begin rd(`PMRA_A_IST, d); n++; end while (d[3] !== 1'b1 && n < 64);
      guard(n);
    end
  endtask
  task automatic wait_kind(input pmra_kind_t k);
    int n;
    n = 0;
    do begin @(posedge aclk); n++; end while (conv_kind !== k && n < 64);
    guard(n);
    repeat (2) @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], d);
      chk(d, rv[i]);
    end
    chk({31'h0, adc_range}, 32'h0000_0000);
    chk({31'h0, conv_run}, 32'h0000_0001);
    rd(8'h1C, d);
    chk(d, 32'h0000_0000);
    chk({30'h0, last_r}, 32'h0000_0002);
    wr(`PMRA_A_SHUNT, 32'h0000_0001);
    chk({30'h0, last_b}, 32'h0000_0002);
  endtask
  task automatic s_results();
    logic [31:0] d;
    sh <= 16'h03E8; bu <= 16'h0280; te <= 16'hFFF0;
    settle();
    rd(`PMRA_A_CUR, d); chk(d, 32'h0000_0000);
    rd(`PMRA_A_PWR, d); chk(d, 32'h0000_0000);
    rd(`PMRA_A_SHUNT, d); chk({16'h0, d[15:0]}, 32'h0000_03E8);
    rd(`PMRA_A_TEMP, d); chk({16'h0, d[15:0]}, 32'h0000_FFF0);
    wr(`PMRA_A_CAL, 32'h0000_0800);
    settle();
    rd(`PMRA_A_CUR, d); chk(d, 32'h0000_03E8);
    rd(`PMRA_A_PWR, d); chk(d, 32'h0000_2710);
  endtask
  task automatic s_limits();
    logic [31:0] d;
    wr(`PMRA_A_SOL, 32'h0000_03E7); wr(`PMRA_A_PWL, 32'h0000_0026);
    wr(`PMRA_A_ALEN, 32'h0000_0007); wr(`PMRA_A_IEN, 32'h0000_0007);
    settle();
    rd(`PMRA_A_FLAGS, d); chk({29'h0, d[2:0]}, 32'h0000_0005);
    chk({30'h0, alert, irq}, 32'h0000_0003);
    wr(`PMRA_A_BOL, 32'h0000_027F);
    settle();
    rd(`PMRA_A_FLAGS, d); chk({29'h0, d[2:0]}, 32'h0000_0007);
    wr(`PMRA_A_SOL, 32'h0000_7FFF); wr(`PMRA_A_BOL, 32'h0000_7FFF); wr(`PMRA_A_PWL, 32'h0000_FFFF);
    settle();
    chk({31'h0, alert}, 32'h0000_0000);
    rd(`PMRA_A_IST, d); chk({29'h0, d[2:0]}, 32'h0000_0007);
    wr(`PMRA_A_ICLR, 32'h0000_0007);
    rd(`PMRA_A_IST, d); chk({29'h0, d[2:0]}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask
  task automatic s_modes();
    logic [31:0] d;
    int n;
    n = 0;
    wr(`PMRA_A_CFG, 32'h0000_0003);
    do begin @(posedge aclk); n++; end while (alert !== 1'b1 && n < 64);
    chk({31'h0, alert}, 32'h0000_0001);
    chk({31'h0, adc_range}, 32'h0000_0001);
    wr(`PMRA_A_CFG, 32'h0000_0000);
    wr(`PMRA_A_ADCCFG, 32'h0000_3C88);
    wait_kind(KIND_BUS); chk({29'h0, conv_time}, 32'h0000_0006);
    wait_kind(KIND_SHUNT); chk({29'h0, conv_time}, 32'h0000_0002);
    bu <= 16'hFFF6;
    settle();
    rd(`PMRA_A_BUS, d); chk({16'h0, d[15:0]}, 32'h0000_0000);
    wr(`PMRA_A_ADCCFG, 32'h0000_1C88);
    settle();
    chk({30'h0, conv_kind}, 32'h0000_0000);
    wr(`PMRA_A_ADCCFG, 32'h0000_0C88);
    @(posedge aclk);
    chk({31'h0, conv_run}, 32'h0000_0000);
    wr(`PMRA_A_SOL, 32'h0000_1234);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PMRA_A_SOL, d); chk(d, 32'h0000_7FFF);
    rd(`PMRA_A_ADCCFG, d); chk(d, 32'h0000_3B68);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset();
    s_results();
    s_limits();
    s_modes();
    print_verdict();
  end
endmodule // tb_top

bind pmra_top pmra_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sample_valid(sample_valid), .conv_kind(conv_kind), .conv_run(conv_run),
  .alert(alert), .irq(irq));
